// [logic/tps_defs.svh]
// Constants for the tuner status and band-select link, both ends.
// Assumes one 125 MHz clock shared by both ends.
`ifndef TPS_DEFS_SVH
`define TPS_DEFS_SVH
`define TPS_ADDR_N1_HI    4'h0
`define TPS_ADDR_N1_LO    4'h1
`define TPS_ADDR_R1       4'h2
`define TPS_ADDR_N2_HI    4'h3
`define TPS_ADDR_N2_LO    4'h4
`define TPS_ADDR_R2       4'h5
`define TPS_ADDR_OSC_SEL  4'h6
`define TPS_ADDR_TEST     4'h7
`define TPS_ADDR_FILTER   4'h8
`define TPS_NUM_WREGS     9
`define TPS_ADDR_STATUS   4'h1
`define TPS_ST_FIRST_LOOP_LOCK_FLAG      7
`define TPS_ST_SECOND_LOOP_LOCK_FLAG      6
`define TPS_ST_POR        5
`define TPS_ST_RANGE1     4
`define TPS_ST_RANGE2     3
`define TPS_TANK_HI       7
`define TPS_TANK_LO       5
`define TPS_FSTEP_HI      5
`define TPS_FSTEP_LO      4
`define TPS_MON_HI        3
`define TPS_MON_LO        0
`define TPS_RST_WREG      8'h00
`define TPS_RST_FILTER    8'h10
`define TPS_MON_QUIET     4'h0
`define TPS_MON_FIRST_LOOP_LOCK_FLAG     4'h1
`define TPS_MON_SECOND_LOOP_LOCK_FLAG     4'h2
`define TPS_MON_AND       4'h8
`define TPS_MON_NAND      4'h9
`define TPS_MON_RANGE1    4'hA
`define TPS_MON_RANGE2    4'hB
`define TPS_R1_RATIO      8'h04
`define TPS_R2_RATIO_44   8'h10
`define TPS_R2_RATIO_36   8'h1C
`define TPS_POR_CYC       4'hF
`define TPS_CLK_NS        8
`define TPS_SETTLE_NS     10000
`define TPS_SETTLE_CYC    ((`TPS_SETTLE_NS + `TPS_CLK_NS - 1) / `TPS_CLK_NS)
`define TPS_AV_CTRL       2'h0
`define TPS_AV_STATUS     2'h1
`define TPS_AV_RAWWR      2'h2
`endif

// [logic/tps_pkg.sv]
// Types shared by the tuner status and band-select ends.
// Assumes tps_defs.svh holds the numeric constants.
package tps_pkg;
    typedef enum logic [2:0] {
        HS_IDLE   = 3'b000,
        HS_WR_R1  = 3'b001,
        HS_WR_R2  = 3'b010,
        HS_WR_OSC = 3'b011,
        HS_SETTLE = 3'b100,
        HS_RD_REQ = 3'b101,
        HS_RD_WT  = 3'b110,
        HS_RAW    = 3'b111
    } tps_hstate_t;
endpackage : tps_pkg

// [logic/tps_link_if.sv]
// Configuration link between the tuner end and its host controller.
// Assumes both ends run on the same clk; strobes are one-cycle pulses.
`timescale 1ns/10ps
interface tps_link_if (
    input wire logic clk
);
    logic       wrStb;
    logic       rdStb;
    logic [3:0] regAddr;
    logic [7:0] wrData;
    logic [7:0] rdData;
    logic       rdValid;
    modport dev  (input clk, input wrStb, input rdStb, input regAddr, input wrData,
                  output rdData, output rdValid);
    modport host (input clk, output wrStb, output rdStb, output regAddr, output wrData,
                  input rdData, input rdValid);
endinterface : tps_link_if

// [logic/tps_tuner_dev.sv]
// Tuner end: configuration registers, status readback, monitor pin select.
// Assumes the loop and tune-range indicators arrive asynchronously.
`timescale 1ns/10ps
`include "tps_defs.svh"
// Behaviour
// - Lock flags in status bits 7, 6
// - Bit 5 set after reset completes
// - Range flags bits 4, 3; rest reserved
// - Host steps tank down on under
// - Host steps tank up on over
// - One of eight tanks, host-selected
// - Filter step bits at address 8
// - Host programs recommended reference dividers
// - Tank code bits 7:5, ascending frequency
// - Monitor field routes signals to pin
module tps_tuner_dev (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    tps_link_if.dev         link,
    input  wire logic       lock1Raw,
    input  wire logic       lock2Raw,
    input  wire logic       range1Raw,
    input  wire logic       range2Raw,
    output logic      [2:0] tankSel,
    output logic      [1:0] filterStep,
    output logic      [4:0] firstRefDiv,
    output logic      [6:0] secondRefDiv,
    output logic     [12:0] firstFbDiv,
    output logic     [15:0] secondFbDiv,
    output logic      [1:0] firstPumpSel,
    output logic      [1:0] secondPumpSel,
    output logic      [7:0] testByte,
    output logic            monitorOut
);
    logic [7:0] cfgMem_reg  [0:`TPS_NUM_WREGS-1];
    logic [7:0] cfgMem_next [0:`TPS_NUM_WREGS-1];

    logic [3:0] syncA_reg;
    logic [3:0] syncA_next;
    logic [3:0] syncB_reg;
    logic [3:0] syncB_next;

    logic [3:0] porCnt_reg;
    logic [3:0] porCnt_next;
    logic       porDone_reg;
    logic       porDone_next;

    logic [7:0] rdData_reg;
    logic [7:0] rdData_next;
    logic       rdValid_reg;
    logic       rdValid_next;

    logic       mon_reg;
    logic       mon_next;

    // Combinational views
    logic [7:0] statusByte;
    logic       first_loop_lock_flag;
    logic       second_loop_lock_flag;
    logic       range1;
    logic       range2;
    logic [3:0] monSel;

    // Indicator synchronisers; stage A feeds only stage B
    always_comb begin
        syncA_next = {lock1Raw, lock2Raw, range1Raw, range2Raw};
        syncB_next = syncA_reg;
    end

    // Clears to zero so release shows no false lock
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            syncA_reg <= 4'h0;
            syncB_reg <= 4'h0;
        end else begin
            syncA_reg <= syncA_next;
            syncB_reg <= syncB_next;
        end
    end

    assign first_loop_lock_flag  = syncB_reg[3];
    assign second_loop_lock_flag  = syncB_reg[2];
    assign range1 = syncB_reg[1];
    assign range2 = syncB_reg[0];

    // Low through the count, so early reads see reset pending
    // reset completion flag
    always_comb begin
        porCnt_next  = porCnt_reg;
        porDone_next = porDone_reg;
        if (porCnt_reg != `TPS_POR_CYC) begin
            porCnt_next = porCnt_reg + 4'h1;
        end else begin
            porDone_next = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            porCnt_reg  <= 4'h0;
            porDone_reg <= 1'b0;
        end else begin
            porCnt_reg  <= porCnt_next;
            porDone_reg <= porDone_next;
        end
    end

    // Reserved bits stay zero on every read
    // lock flag placement
    always_comb begin
        statusByte                = 8'h00;
        statusByte[`TPS_ST_FIRST_LOOP_LOCK_FLAG]  = first_loop_lock_flag;
        statusByte[`TPS_ST_SECOND_LOOP_LOCK_FLAG]  = second_loop_lock_flag;
        statusByte[`TPS_ST_POR]    = porDone_reg;
        statusByte[`TPS_ST_RANGE1] = range1;
        statusByte[`TPS_ST_RANGE2] = range2;
    end

    // Write side; addresses past the map are dropped
    for (genvar g = 0; g < `TPS_NUM_WREGS; g++) begin : g_cfg
        // Filter entry wakes at its nominal centre, the rest at zero
        localparam logic [7:0] RST_VAL =
            (g == `TPS_ADDR_FILTER) ? `TPS_RST_FILTER : `TPS_RST_WREG;

        always_comb begin
            cfgMem_next[g] = cfgMem_reg[g];
            if (link.wrStb && (link.regAddr == 4'(g))) begin
                cfgMem_next[g] = link.wrData;
            end
        end

        always_ff @(posedge clk) begin
            if (sys_rst) begin
                cfgMem_reg[g] <= RST_VAL;
            end else begin
                cfgMem_reg[g] <= cfgMem_next[g];
            end
        end
    end

    // Data holds between reads; rdValid marks a fresh answer
    // read returns live flags only
    always_comb begin
        rdValid_next = link.rdStb;
        rdData_next  = rdData_reg;
        if (link.rdStb) begin
            rdData_next = (link.regAddr == `TPS_ADDR_STATUS) ? statusByte : 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdData_reg  <= 8'h00;
            rdValid_reg <= 1'b0;
        end else begin
            rdData_reg  <= rdData_next;
            rdValid_reg <= rdValid_next;
        end
    end

    assign link.rdData  = rdData_reg;
    assign link.rdValid = rdValid_reg;

    // Registered so the pin never glitches on a select change
    // monitor pin routing
    assign monSel = cfgMem_reg[`TPS_ADDR_FILTER][`TPS_MON_HI:`TPS_MON_LO];
    always_comb begin
        mon_next = 1'b0;
        // Divider and reference taps are not modelled; they stay quiet
        unique case (monSel)
            `TPS_MON_FIRST_LOOP_LOCK_FLAG:  mon_next = first_loop_lock_flag;
            `TPS_MON_SECOND_LOOP_LOCK_FLAG:  mon_next = second_loop_lock_flag;
            `TPS_MON_AND:    mon_next = first_loop_lock_flag & second_loop_lock_flag;
            `TPS_MON_NAND:   mon_next = ~(first_loop_lock_flag & second_loop_lock_flag);
            `TPS_MON_RANGE1: mon_next = range1;
            `TPS_MON_RANGE2: mon_next = range2;
            default:         mon_next = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mon_reg <= 1'b0;
        end else begin
            mon_reg <= mon_next;
        end
    end

    assign monitorOut = mon_reg;

    assign tankSel = cfgMem_reg[`TPS_ADDR_OSC_SEL][`TPS_TANK_HI:`TPS_TANK_LO];
    assign filterStep = cfgMem_reg[`TPS_ADDR_FILTER][`TPS_FSTEP_HI:`TPS_FSTEP_LO];

    // Pump and divider fields pass straight to the loops
    assign firstPumpSel  = cfgMem_reg[`TPS_ADDR_OSC_SEL][3:2];
    assign secondPumpSel = cfgMem_reg[`TPS_ADDR_OSC_SEL][1:0];

    assign firstRefDiv   = cfgMem_reg[`TPS_ADDR_R1][4:0];
    assign secondRefDiv  = cfgMem_reg[`TPS_ADDR_R2][6:0];
    assign firstFbDiv    = {cfgMem_reg[`TPS_ADDR_N1_HI][4:0], cfgMem_reg[`TPS_ADDR_N1_LO]};
    assign secondFbDiv   = {cfgMem_reg[`TPS_ADDR_N2_HI], cfgMem_reg[`TPS_ADDR_N2_LO]};
    assign testByte      = cfgMem_reg[`TPS_ADDR_TEST];

endmodule : tps_tuner_dev

// [logic/tps_host_ctl.sv]
// Host controller: Avalon-MM slave that runs the tank search over the link.
// Assumes the tuner end answers a read with rdValid one cycle after rdStb.
//
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
`include "tps_defs.svh"
module tps_host_ctl (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    tps_link_if.host         link,
    input  wire logic  [1:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest
);
    localparam int SETTLE_CYC = `TPS_SETTLE_CYC;
    tps_pkg::tps_hstate_t st_reg, st_next;
    logic        wait_reg, wait_next;
    logic [31:0] rdat_reg, rdat_next;
    logic  [8:0] ctrl_reg, ctrl_next;
    logic  [2:0] tank_reg, tank_next;
    logic        locked_reg, locked_next;
    logic        failed_reg, failed_next;
    logic  [7:0] last_reg, last_next;
    logic [11:0] raw_reg, raw_next;
    logic [10:0] cnt_reg, cnt_next;
    logic        wr_reg, wr_next;
    logic        rd_reg, rd_next;
    logic  [3:0] addr_reg, addr_next;
    logic  [7:0] wdat_reg, wdat_next;
    logic        busy;
    logic        accWr;

    assign busy  = (st_reg != tps_pkg::HS_IDLE);
    assign accWr = avs_write && !wait_reg;

    always_comb begin
        st_next     = st_reg;
        wait_next   = 1'b1;
        rdat_next   = rdat_reg;
        ctrl_next   = ctrl_reg;
        tank_next   = tank_reg;
        locked_next = locked_reg;
        failed_next = failed_reg;
        last_next   = last_reg;
        raw_next    = raw_reg;
        cnt_next    = cnt_reg;
        wr_next     = 1'b0;
        rd_next     = 1'b0;
        addr_next   = addr_reg;
        wdat_next   = wdat_reg;
        // One wait cycle, then a single low cycle that completes the access
        if ((avs_read || avs_write) && wait_reg) begin
            wait_next = 1'b0;
            unique case (avs_address)
                `TPS_AV_CTRL:   rdat_next = {23'h0, ctrl_reg};
                `TPS_AV_STATUS: rdat_next = {16'h0, last_reg, 2'h0, tank_reg,
                                             failed_reg, locked_reg, busy};
                default:        rdat_next = 32'h0;
            endcase
        end
        unique case (st_reg)
            tps_pkg::HS_IDLE: begin
                if (accWr && avs_address == `TPS_AV_CTRL) begin
                    ctrl_next = {avs_writedata[8:1], 1'b0};
                    if (avs_writedata[0]) begin
                        tank_next   = avs_writedata[4:2];
                        locked_next = 1'b0;
                        failed_next = 1'b0;
                        st_next     = tps_pkg::HS_WR_R1;
                    end
                end else if (accWr && avs_address == `TPS_AV_RAWWR) begin
                    raw_next = avs_writedata[11:0];
                    st_next  = tps_pkg::HS_RAW;
                end
            end
            tps_pkg::HS_RAW: begin
                wr_next   = 1'b1;
                addr_next = raw_reg[11:8];
                wdat_next = raw_reg[7:0];
                st_next = tps_pkg::HS_IDLE;
            end
            tps_pkg::HS_WR_R1: begin
                wr_next   = 1'b1;
                addr_next = `TPS_ADDR_R1;
                wdat_next = `TPS_R1_RATIO;
                st_next = tps_pkg::HS_WR_R2;
            end
            tps_pkg::HS_WR_R2: begin
                wr_next   = 1'b1;
                addr_next = `TPS_ADDR_R2;
                wdat_next = ctrl_reg[1] ? `TPS_R2_RATIO_36 : `TPS_R2_RATIO_44;
                st_next = tps_pkg::HS_WR_OSC;
            end
            tps_pkg::HS_WR_OSC: begin
                wr_next   = 1'b1;
                addr_next = `TPS_ADDR_OSC_SEL;
                wdat_next = {tank_reg, 1'b0, ctrl_reg[8:5]};
                cnt_next = 11'(SETTLE_CYC - 1);
                st_next = tps_pkg::HS_SETTLE;
            end
            tps_pkg::HS_SETTLE: begin
                cnt_next = cnt_reg - 11'h1;
                if (cnt_reg == 11'h0) begin
                    st_next = tps_pkg::HS_RD_REQ;
                end
            end
            tps_pkg::HS_RD_REQ: begin
                rd_next   = 1'b1;
                addr_next = `TPS_ADDR_STATUS;
                st_next = tps_pkg::HS_RD_WT;
            end
            tps_pkg::HS_RD_WT: begin
                if (link.rdValid) begin
                    last_next = link.rdData;
                    st_next   = tps_pkg::HS_IDLE;
                    if (link.rdData[`TPS_ST_FIRST_LOOP_LOCK_FLAG]) begin
                        locked_next = 1'b1;
                    end else if (!link.rdData[`TPS_ST_RANGE1]) begin
                        if (tank_reg == 3'h0) failed_next = 1'b1;
                        else begin
                            tank_next = tank_reg - 3'h1;
                            st_next   = tps_pkg::HS_WR_OSC;
                        end
                    end else begin
                        if (tank_reg == 3'h7) failed_next = 1'b1;
                        else begin
                            tank_next = tank_reg + 3'h1;
                            st_next   = tps_pkg::HS_WR_OSC;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg     <= tps_pkg::HS_IDLE;
            wait_reg   <= 1'b1;
            rdat_reg   <= 32'h0;
            ctrl_reg   <= 9'h0;
            tank_reg   <= 3'h0;
            locked_reg <= 1'b0;
            failed_reg <= 1'b0;
            last_reg   <= 8'h00;
            raw_reg    <= 12'h000;
            cnt_reg    <= 11'h0;
            wr_reg     <= 1'b0;
            rd_reg     <= 1'b0;
            addr_reg   <= 4'h0;
            wdat_reg   <= 8'h00;
        end else begin
            st_reg     <= st_next;
            wait_reg   <= wait_next;
            rdat_reg   <= rdat_next;
            ctrl_reg   <= ctrl_next;
            tank_reg   <= tank_next;
            locked_reg <= locked_next;
            failed_reg <= failed_next;
            last_reg   <= last_next;
            raw_reg    <= raw_next;
            cnt_reg    <= cnt_next;
            wr_reg     <= wr_next;
            rd_reg     <= rd_next;
            addr_reg   <= addr_next;
            wdat_reg   <= wdat_next;
        end
    end

    assign avs_waitrequest = wait_reg;
    assign avs_readdata    = rdat_reg;
    assign link.wrStb      = wr_reg;
    assign link.rdStb      = rd_reg;
    assign link.regAddr    = addr_reg;
    assign link.wrData     = wdat_reg;

endmodule : tps_host_ctl

// [testbench/tps_link_assertions.sv]
// Checker for the tuner configuration link, watching both ends' traffic.
// Assumes one clk and synchronous active-high sys_rst shared by both ends.
`timescale 1ns/10ps
module tps_link_assertions (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       wrStb,
    input wire logic       rdStb,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] wrData,
    input wire logic [7:0] rdData,
    input wire logic       rdValid
);
    logic [5:0] porCnt_reg;
    logic [5:0] porCnt_next;
    logic [2:0] lastTank_reg;
    logic [2:0] lastTank_next;
    // Saturates so late reads never wrap back into the reset window
    always_comb begin
        porCnt_next = (porCnt_reg == 6'h3F) ? porCnt_reg : porCnt_reg + 6'h01;
        lastTank_next = (wrStb && regAddr == 4'h6) ? wrData[7:5] : lastTank_reg;
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            porCnt_reg <= 6'h00;
            lastTank_reg <= 3'h0;
        end else begin
            porCnt_reg <= porCnt_next;
            lastTank_reg <= lastTank_next;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_ref1;
        wrStb && regAddr == 4'h2 && wrData == 8'h04;
    endsequence
    sequence s_ref2_tank;
        wrStb && regAddr == 4'h5 && (wrData == 8'h10 || wrData == 8'h1C)
        ##1 wrStb && regAddr == 4'h6 && wrData[4] == 1'b0;
    endsequence
    property p_rd_answer;
        rdStb |=> rdValid ##1 !rdValid;
    endproperty
    property p_rd_cause;
        rdValid |-> $past(rdStb);
    endproperty
    property p_rd_status_only;
        rdStb |-> regAddr == 4'h1;
    endproperty
    property p_reserved_zero;
        rdValid |-> rdData[2:0] == 3'h0;
    endproperty
    property p_por_flag;
        rdValid && porCnt_reg >= 6'h14 |-> rdData[5];
    endproperty
    property p_div_order;
        s_ref1 |=> s_ref2_tank;
    endproperty
    property p_step_down;
        rdValid && !rdData[7] && !rdData[4] && lastTank_reg != 3'h0
        |-> ##[1:8] (wrStb && regAddr == 4'h6 && wrData[7:5] == lastTank_reg - 3'h1);
    endproperty
    property p_step_up;
        rdValid && !rdData[7] && rdData[4] && lastTank_reg != 3'h7
        |-> ##[1:8] (wrStb && regAddr == 4'h6 && wrData[7:5] == lastTank_reg + 3'h1);
    endproperty
    property p_locked_stop;
        rdValid && rdData[7] |=> !wrStb [*8];
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    a_rd_cause: assert property (p_rd_cause) else $error("stray read answer");
    a_rd_status_only: assert property (p_rd_status_only) else $error("read off status");
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");
    a_por_flag: assert property (p_por_flag) else $error("reset flag low");
    a_div_order: assert property (p_div_order) else $error("divider order");
    a_step_down: assert property (p_step_down) else $error("no lower tank");
    a_step_up: assert property (p_step_up) else $error("no higher tank");
    a_locked_stop: assert property (p_locked_stop) else $error("retune after lock");
endmodule : tps_link_assertions

// [testbench/tuner_pll_status_and_band_select_bench.sv]
// Bench joining host controller and tuner end, with a register model.
// Assumes Avalon answers after one wait state and search settles 1250 cycles.
`timescale 1ns/10ps
`include "tps_defs.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module tuner_pll_status_and_band_select_bench;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        lock1Raw = 1'b0;
    logic        lock2Raw = 1'b0;
    logic        range1Raw = 1'b0;
    logic        range2Raw = 1'b0;
    logic [1:0]  avs_address = 2'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [2:0]  tankSel;
    logic [1:0]  filterStep, firstPumpSel, secondPumpSel;
    logic [4:0]  firstRefDiv;
    logic [6:0]  secondRefDiv;
    logic [12:0] firstFbDiv;
    logic [15:0] secondFbDiv;
    logic [7:0]  testByte;
    logic        monitorOut;
    logic [7:0]  rm [0:8];
    logic [31:0] q;
    logic        ex;
    int          errors = 0;
    int          tests_run = 0;
    always #4 clk = ~clk;
    tps_link_if link (.clk(clk));
    tps_tuner_dev tps_tuner_dev_i (.clk(clk), .sys_rst(sys_rst), .link(link),
        .lock1Raw(lock1Raw), .lock2Raw(lock2Raw), .range1Raw(range1Raw),
        .range2Raw(range2Raw), .tankSel(tankSel), .filterStep(filterStep),
        .firstRefDiv(firstRefDiv), .secondRefDiv(secondRefDiv), .firstFbDiv(firstFbDiv),
        .secondFbDiv(secondFbDiv), .firstPumpSel(firstPumpSel),
        .secondPumpSel(secondPumpSel), .testByte(testByte), .monitorOut(monitorOut));
    tps_host_ctl tps_host_ctl_i (.clk(clk), .sys_rst(sys_rst), .link(link),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    tps_link_assertions tps_link_assertions_i (.clk(clk), .sys_rst(sys_rst),
        .wrStb(link.wrStb), .rdStb(link.rdStb), .regAddr(link.regAddr),
        .wrData(link.wrData), .rdData(link.rdData), .rdValid(link.rdValid));
    task end_sim;
        $display("Checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    task av(input logic wr, input logic [1:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 64);
        if (n >= 64) begin
            errors++;
            $display("[FAIL] waitrequest expected 0 seen 1");
            end_sim();
        end
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : av
    task chk_outs;
        `CHK("tankSel", rm[6][7:5], tankSel)
        `CHK("pumps", rm[6][3:0], {firstPumpSel, secondPumpSel})
        `CHK("filterStep", rm[8][5:4], filterStep)
        `CHK("firstRefDiv", rm[2][4:0], firstRefDiv)
        `CHK("secondRefDiv", rm[5][6:0], secondRefDiv)
        `CHK("firstFbDiv", {rm[0][4:0], rm[1]}, firstFbDiv)
        `CHK("secondFbDiv", {rm[3], rm[4]}, secondFbDiv)
        `CHK("testByte", rm[7], testByte)
    endtask : chk_outs
    task raw(input logic [3:0] a, input logic [7:0] d);
        av(1'b1, `TPS_AV_RAWWR, {20'h0, a, d}, q);
        if (a <= 4'h8)
            rm[a] = d;
        repeat (4) @(posedge clk);
    endtask : raw
    task search(input logic [2:0] st, input logic [3:0] cp, input logic v36, input logic lk);
        int n;
        logic [2:0] tk;
        lock1Raw <= lk;
        lock2Raw <= 1'($urandom);
        range2Raw <= 1'($urandom);
        repeat (4) @(posedge clk);
        av(1'b1, `TPS_AV_CTRL, {23'h0, cp, st, v36, 1'b1}, q);
        n = 0;
        do begin
            av(1'b0, `TPS_AV_STATUS, 32'h0, q);
            n++;
        end while (q[0] !== 1'b0 && n < 3000);
        if (n >= 3000) begin
            `CHK("busy", 1'b0, q[0])
            end_sim();
        end
        // Lock wins; otherwise the walk runs to the end tank and fails
        tk = lk ? st : (range1Raw ? 3'h7 : 3'h0);
        `CHK("status", {16'h0, lk, lock2Raw, 1'b1, range1Raw, range2Raw, 5'h0, tk, !lk, lk,
            1'b0}, q & 32'h0000FF3F)
        av(1'b0, `TPS_AV_CTRL, 32'h0, q);
        `CHK("ctrl", {23'h0, cp, st, v36, 1'b0}, q)
        rm[2] = 8'h04;
        rm[5] = v36 ? 8'h1C : 8'h10;
        rm[6] = {tk, 1'b0, cp};
        chk_outs();
        // Quiet gap keeps bench writes clear of the lock window
        repeat (10) @(posedge clk);
        $display("search from %0d done", st);
    endtask : search
    initial begin
        void'($urandom(57));
        for (int i = 0; i < 9; i++)
            rm[i] = `TPS_RST_WREG;
        rm[8] = `TPS_RST_FILTER;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk_outs();
        `CHK("monitorOut", 1'b0, monitorOut)
        av(1'b0, 2'h3, 32'h0, q);
        `CHK("unmapped", 32'h0, q)
        $display("reset test done");
        raw(4'h9, 8'hFF);
        for (int i = 0; i < 20; i++) begin
            raw(4'($urandom_range(8, 0)), 8'($urandom) | 8'h08);
            chk_outs();
        end
        $display("register test done");
        for (int c = 0; c < 16; c++) begin
            {lock1Raw, lock2Raw, range1Raw, range2Raw} <= 4'($urandom);
            raw(4'h8, {2'h0, 2'($urandom), 4'(c)});
            repeat (4) @(posedge clk);
            case (c)
                1: ex = lock1Raw;
                2: ex = lock2Raw;
                8: ex = lock1Raw & lock2Raw;
                9: ex = ~(lock1Raw & lock2Raw);
                10: ex = range1Raw;
                11: ex = range2Raw;
                default: ex = 1'b0;
            endcase
            `CHK("monitorOut", ex, monitorOut)
            chk_outs();
        end
        $display("monitor test done");
        range1Raw <= 1'b0;
        search(3'h1, 4'h5, 1'b0, 1'b0);
        range1Raw <= 1'b1;
        search(3'h6, 4'hA, 1'b1, 1'b0);
        range1Raw <= 1'($urandom);
        search(3'($urandom), 4'($urandom), 1'($urandom), 1'b1);
        end_sim();
    end
endmodule : tuner_pll_status_and_band_select_bench
